// *** src/ccr_core_control.sv ***
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_params.svh"

module ccr_core_control (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic [`CCR_ADDR_W-1:0]   i_addr,
  input  wire logic [15:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic [2:0]               i_priority_level_low_bits,
  input  wire logic                     i_priority_msb_set,
  input  wire logic                     i_loop_enter,
  input  wire logic                     i_loop_done,
  input  wire logic                     i_iteration_end,
  output logic      [15:0]              o_rdata,
  output ccr_pkg::ccr_ctrl_t            o_ctrl,
  output logic                          o_loop_terminate,
  output logic      [2:0]               o_loop_nesting_depth
);

  logic [15:0]          rdata_reg;
  logic [15:0]          rdata_next;
  logic                 var_reg;
  logic                 var_next;
  ccr_pkg::ccr_mul_mode_t mul_reg;
  ccr_pkg::ccr_mul_mode_t mul_next;
  logic                 acc_a_saturate_en_reg;
  logic                 acc_a_saturate_en_next;
  logic                 acc_b_saturate_en_reg;
  logic                 acc_b_saturate_en_next;
  logic                 store_saturate_en_reg;
  logic                 store_saturate_en_next;
  logic                 super_reg;
  logic                 super_next;
  logic                 priority_level_msb_reg;
  logic                 priority_level_msb_next;
  logic [2:0]           low_reg;
  logic [2:0]           low_next;
  logic                 exit_pend_reg;
  logic                 exit_pend_next;
  logic                 term_reg;
  logic                 term_next;
  logic [2:0]           depth_reg;
  logic [2:0]           depth;
  ccr_pkg::ccr_ctrl_t   ctrl_reg;
  ccr_pkg::ccr_ctrl_t   ctrl_next;
  logic                 wr_ctrl;
  logic                 rd_ctrl;

  ////////////////////////////////////////////////////////////////////
  // Nesting depth tracker
  ccr_loop_depth u_depth (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_loop_enter (i_loop_enter),
    .i_loop_done  (i_loop_done),
    .o_depth      (depth)
  );

  // Address decode shared by both strobes
  function automatic logic ccr_hit(input logic [`CCR_ADDR_W-1:0] a);
    return a == `CCR_CORE_CTRL_OFF;
  endfunction

  // Strobes qualified by the one mapped address
  assign wr_ctrl = i_wr && ccr_hit(i_addr);
  assign rd_ctrl = i_rd && ccr_hit(i_addr);

  // Assemble the readback word
  function automatic logic [15:0] ccr_pack(
    input logic       v,
    input logic [1:0] m,
    input logic [2:0] d,
    input logic       a,
    input logic       b,
    input logic       s,
    input logic       sup,
    input logic       p,
    input logic [2:0] l
  );
    logic [15:0] w;
    w = 16'h0000;
    w[`CCR_VAR_BIT] = v;
    w[`CCR_MUL_HI:`CCR_MUL_LO] = m;
    w[`CCR_DEPTH_HI:`CCR_DEPTH_LO] = d;
    w[`CCR_ACC_A_SATURATE_EN_BIT] = a;
    w[`CCR_ACC_B_SATURATE_EN_BIT] = b;
    w[`CCR_STORE_SATURATE_EN_BIT] = s;
    w[`CCR_SUPER_BIT] = sup;
    w[`CCR_PRIORITY_LEVEL_MSB_BIT] = p;
    w[`CCR_LOW_HI:`CCR_LOW_LO] = l;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Field next-state logic
  always_comb begin
    var_next   = var_reg;
    mul_next   = mul_reg;
    acc_a_saturate_en_next  = acc_a_saturate_en_reg;
    acc_b_saturate_en_next  = acc_b_saturate_en_reg;
    store_saturate_en_next = store_saturate_en_reg;
    super_next = super_reg;
    low_next   = low_reg;
    priority_level_msb_next  = priority_level_msb_reg;
    if (wr_ctrl) begin
      var_next   = i_wdata[`CCR_VAR_BIT];
      // Reserved code is stored as written; software must avoid it
      mul_next   = ccr_pkg::ccr_mul_mode_t'(
                     i_wdata[`CCR_MUL_HI:`CCR_MUL_LO]);
      acc_a_saturate_en_next  = i_wdata[`CCR_ACC_A_SATURATE_EN_BIT];
      acc_b_saturate_en_next  = i_wdata[`CCR_ACC_B_SATURATE_EN_BIT];
      store_saturate_en_next = i_wdata[`CCR_STORE_SATURATE_EN_BIT];
      super_next = i_wdata[`CCR_SUPER_BIT];
      low_next   = i_wdata[`CCR_LOW_HI:`CCR_LOW_LO];
      if (!i_wdata[`CCR_PRIORITY_LEVEL_MSB_BIT]) begin
        priority_level_msb_next = 1'b0;
      end
    end
    // Hardware set beats a software clear in the same cycle
    if (i_priority_msb_set) begin
      priority_level_msb_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Early exit: held until the running iteration ends
  always_comb begin
    exit_pend_next = exit_pend_reg;
    term_next      = 1'b0;
    if (wr_ctrl && i_wdata[`CCR_EXIT_BIT] &&
        depth_reg != `CCR_DEPTH_RST) begin
      exit_pend_next = 1'b1;
    end
    if ((exit_pend_reg || exit_pend_next) && i_iteration_end) begin
      term_next      = 1'b1;
      exit_pend_next = 1'b0;
    end
    // Once every loop has finished on its own, a stale request is dropped
    if (depth_reg == `CCR_DEPTH_RST) begin
      exit_pend_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs and readback; exit bit and bit 14 always read zero
  always_comb begin
    ctrl_next.variable_latency        = var_next;
    ctrl_next.multiply_sign_mode      = mul_next;
    ctrl_next.acc_a_saturate_en       = acc_a_saturate_en_next;
    ctrl_next.acc_b_saturate_en       = acc_b_saturate_en_next;
    ctrl_next.store_saturate_en       = store_saturate_en_next;
    ctrl_next.super_saturation_select = super_next;
    // Low bits follow the status word, one cycle late
    ctrl_next.priority_level = {priority_level_msb_next,
                                i_priority_level_low_bits};
    rdata_next = 16'h0000;
    if (rd_ctrl) begin
      rdata_next = ccr_pack(var_reg, mul_reg, depth_reg, acc_a_saturate_en_reg,
                            acc_b_saturate_en_reg, store_saturate_en_reg, super_reg, priority_level_msb_reg,
                            low_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // All state but the u_depth nesting counter and its state flop registered here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      var_reg       <= 1'b0;
      mul_reg       <= ccr_pkg::CCR_MUL_SIGNED;
      acc_a_saturate_en_reg      <= 1'b0;
      acc_b_saturate_en_reg      <= 1'b0;
      store_saturate_en_reg     <= `CCR_STORE_SATURATE_EN_RST;
      super_reg     <= 1'b0;
      priority_level_msb_reg      <= 1'b0;
      low_reg       <= `CCR_LOW_RST;
      exit_pend_reg <= 1'b0;
      term_reg      <= 1'b0;
      depth_reg     <= `CCR_DEPTH_RST;
      rdata_reg     <= 16'h0000;
      // One assignment per field, so no field is written twice
      ctrl_reg.variable_latency        <= 1'b0;
      ctrl_reg.multiply_sign_mode      <= ccr_pkg::CCR_MUL_SIGNED;
      ctrl_reg.acc_a_saturate_en       <= 1'b0;
      ctrl_reg.acc_b_saturate_en       <= 1'b0;
      ctrl_reg.store_saturate_en       <= `CCR_STORE_SATURATE_EN_RST;
      ctrl_reg.super_saturation_select <= 1'b0;
      ctrl_reg.priority_level          <= 4'h0;
    end else begin
      var_reg       <= var_next;
      mul_reg       <= mul_next;
      acc_a_saturate_en_reg      <= acc_a_saturate_en_next;
      acc_b_saturate_en_reg      <= acc_b_saturate_en_next;
      store_saturate_en_reg     <= store_saturate_en_next;
      super_reg     <= super_next;
      priority_level_msb_reg      <= priority_level_msb_next;
      low_reg       <= low_next;
      exit_pend_reg <= exit_pend_next;
      term_reg      <= term_next;
      depth_reg     <= depth; // Copy keeps the output a flop
      rdata_reg     <= rdata_next;
      ctrl_reg      <= ctrl_next;
    end
  end

  assign o_rdata              = rdata_reg;
  assign o_ctrl               = ctrl_reg;
  assign o_loop_terminate     = term_reg;
  assign o_loop_nesting_depth = depth_reg;

endmodule

`default_nettype wire

// *** src/ccr_params.svh ***
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// Register map
`define CCR_ADDR_W        4
`define CCR_CORE_CTRL_OFF 4'h0
`define CCR_LOOP_CMD_OFF  4'h2

// Field positions
`define CCR_VAR_BIT    15
`define CCR_RSV_BIT    14
`define CCR_MUL_HI     13
`define CCR_MUL_LO     12
`define CCR_EXIT_BIT   11
`define CCR_DEPTH_HI   10
`define CCR_DEPTH_LO   8
`define CCR_ACC_A_SATURATE_EN_BIT   7
`define CCR_ACC_B_SATURATE_EN_BIT   6
`define CCR_STORE_SATURATE_EN_BIT  5
`define CCR_SUPER_BIT  4
`define CCR_PRIORITY_LEVEL_MSB_BIT   3
`define CCR_LOW_HI     2
`define CCR_LOW_LO     0

// Reset values and the depth limit
`define CCR_MUL_RST    2'h0
`define CCR_DEPTH_RST  3'h0
`define CCR_DEPTH_MAX  3'h7
`define CCR_STORE_SATURATE_EN_RST  1'h1
`define CCR_LOW_RST    3'h0

// Loop command codes
`define CCR_LOOP_PUSH  2'h1
`define CCR_LOOP_POP   2'h2

`endif

// *** src/ccr_pkg.sv ***
package ccr_pkg;

  typedef enum logic [1:0] {
    CCR_MUL_SIGNED   = 2'h0,
    CCR_MUL_UNSIGNED = 2'h1,
    CCR_MUL_MIXED    = 2'h2,
    CCR_MUL_RESERVED = 2'h3
  } ccr_mul_mode_t;

  // Controls that steer the DSP engine and the core
  typedef struct packed {
    logic          variable_latency;
    ccr_mul_mode_t multiply_sign_mode;
    logic          acc_a_saturate_en;
    logic          acc_b_saturate_en;
    logic          store_saturate_en;
    logic          super_saturation_select;
    logic [3:0]    priority_level;
  } ccr_ctrl_t;

endpackage

// *** src/ccr_loop_depth.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ccr_params.svh"

module ccr_loop_depth (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_loop_enter,
  input  wire logic       i_loop_done,
  output logic      [2:0] o_depth
);

  typedef enum logic {CCR_IDLE, CCR_NESTED} ccr_depth_state_t;

  ccr_depth_state_t state_reg;
  ccr_depth_state_t state_next;
  logic [2:0]       depth_reg;
  logic [2:0]       depth_next;

  ////////////////////////////////////////////////////////////////////
  // Nesting counter, saturates at both ends
  always_comb begin
    depth_next = depth_reg;
    if (i_loop_enter && !i_loop_done && depth_reg != `CCR_DEPTH_MAX) begin
      depth_next = depth_reg + 3'h1;
    end else if (i_loop_done && !i_loop_enter &&
                 depth_reg != `CCR_DEPTH_RST) begin
      depth_next = depth_reg - 3'h1;
    end
    unique case (state_reg)
      CCR_IDLE:   state_next = (depth_next != `CCR_DEPTH_RST) ?
                               CCR_NESTED : CCR_IDLE;
      CCR_NESTED: state_next = (depth_next == `CCR_DEPTH_RST) ?
                               CCR_IDLE : CCR_NESTED;
    endcase
  end

  // Registered state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      depth_reg <= `CCR_DEPTH_RST;
      state_reg <= CCR_IDLE;
    end else begin
      depth_reg <= depth_next;
      state_reg <= state_next;
    end
  end

  assign o_depth = depth_reg;

endmodule

`default_nettype wire

// *** verification/ccr_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ccr_params.svh"
module ccr_props (
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic [`CCR_ADDR_W-1:0] i_addr,
  input wire logic [15:0]            i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [2:0]             i_priority_level_low_bits,
  input wire logic                   i_priority_msb_set,
  input wire logic                   i_loop_enter,
  input wire logic                   i_loop_done,
  input wire logic                   i_iteration_end,
  input wire logic [15:0]            o_rdata,
  input wire ccr_pkg::ccr_ctrl_t     o_ctrl,
  input wire logic                   o_loop_terminate,
  input wire logic [2:0]             o_loop_nesting_depth
);
  // Config fields are the top seven bits of the control struct
  logic [6:0] cfg;
  logic [6:0] wcfg;
  logic       wr0;
  assign cfg  = o_ctrl[10:4];
  assign wcfg = {i_wdata[15], i_wdata[13:12], i_wdata[7:4]};
  assign wr0  = i_wr && i_addr == `CCR_CORE_CTRL_OFF;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  sequence s_wr0;
    wr0;
  endsequence
  a_ctrl_write:
    assert property (s_wr0 |=> cfg == $past(wcfg))
    else $error("control fields differ from write");
  a_ctrl_hold:
    assert property (!wr0 |=> $stable(cfg))
    else $error("control fields moved without write");
  a_rdata_idle:
    assert property (!$past(i_rd) || $past(i_addr) != `CCR_CORE_CTRL_OFF
      |-> o_rdata == 16'h0000) else $error("read data not zero");
  a_fixed_zero:
    assert property (o_rdata[14] == 1'b0 && o_rdata[11] == 1'b0)
    else $error("fixed zero bit read as one");
  a_rd_fields:
    assert property ($past(i_rd) && !$past(wr0)
      && $past(i_addr) == `CCR_CORE_CTRL_OFF
      |-> {o_rdata[15], o_rdata[13:12], o_rdata[7:4]} == cfg)
    else $error("read fields differ from controls");
  a_depth_step:
    assert property (o_loop_nesting_depth > $past(o_loop_nesting_depth)
      |-> $past(i_loop_enter, 2)
      && o_loop_nesting_depth == $past(o_loop_nesting_depth) + 3'h1)
    else $error("depth rose without loop entry");
  a_prio_set:
    assert property ($rose(o_ctrl.priority_level[3])
      |-> $past(i_priority_msb_set) || $past(i_priority_msb_set, 2))
    else $error("priority top bit set by software");
  a_prio_low:
    assert property (!$past(i_rst) && $past(i_priority_level_low_bits)
      == $past(i_priority_level_low_bits, 2)
      |-> o_ctrl.priority_level[2:0] == $past(i_priority_level_low_bits))
    else $error("priority low bits differ from status word");
  a_term_cause:
    assert property (o_loop_terminate |-> $past(i_iteration_end))
    else $error("loop end outside iteration end");
  a_reset_vals:
    assert property (disable iff (1'b0) $fell(i_rst) |-> o_rdata == 16'h0000
      && !o_loop_terminate && o_loop_nesting_depth == 3'h0 && cfg == 7'h02)
    else $error("reset values wrong");
endmodule
// Checker watches every port of the control block
bind ccr_core_control ccr_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_priority_msb_set(i_priority_msb_set),
  .i_priority_level_low_bits(i_priority_level_low_bits),
  .i_loop_enter(i_loop_enter), .i_loop_done(i_loop_done),
  .i_iteration_end(i_iteration_end), .o_rdata(o_rdata), .o_ctrl(o_ctrl),
  .o_loop_terminate(o_loop_terminate),
  .o_loop_nesting_depth(o_loop_nesting_depth)
);
`default_nettype wire

// *** verification/ccr_seq_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccr_seq_model #(
  parameter int ITER = 4
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_terminate,
  output logic      o_loop_enter,
  output logic      o_loop_done,
  output logic      o_iteration_end
);
  int cnt = 0;
  initial begin
    o_loop_enter = 1'b0;
    o_loop_done = 1'b0;
    o_iteration_end = 1'b0;
  end
  // Iteration ends every ITER cycles; a longer ITER models a slow loop
  always @(posedge i_clk) begin
    cnt <= (i_rst || cnt == ITER - 1) ? 0 : cnt + 1;
    o_iteration_end <= !i_rst && cnt == ITER - 1;
    o_loop_enter <= i_start;
    o_loop_done <= i_terminate;
  end
endmodule
`default_nettype wire

// *** verification/ccr_core_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccr_core_control_tb;
  logic               i_clk = 1'b0, i_rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic               msb = 1'b0, start = 1'b0, ent, dn, it_end, term;
  logic [3:0]         addr = 4'h0;
  logic [15:0]        wdata = 16'h0000, rdata;
  logic [2:0]         low_bits = 3'h0, depth;
  ccr_pkg::ccr_ctrl_t ctrl;
  int                 errors = 0, check_count = 0, cyc = 0;
  int                 v, m, a, b, s, sup, priority_level_msb, low, dp;
  int                 terms = 0, exp_terms = 0;
  always #5 i_clk = ~i_clk;
  ccr_core_control dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_priority_msb_set(msb),
    .i_priority_level_low_bits(low_bits), .i_loop_enter(ent),
    .i_loop_done(dn), .i_iteration_end(it_end), .o_rdata(rdata),
    .o_ctrl(ctrl), .o_loop_terminate(term), .o_loop_nesting_depth(depth));
  ccr_seq_model #(.ITER(4)) u_seq (.i_clk(i_clk), .i_rst(i_rst),
    .i_start(start), .i_terminate(term), .o_loop_enter(ent),
    .o_loop_done(dn), .o_iteration_end(it_end));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] exp_rd();
    return {v[0], 1'b0, m[1:0], 1'b0, dp[2:0], a[0], b[0], s[0], sup[0],
      priority_level_msb[0], low[2:0]};
  endfunction
  // Software write; model follows the field access kinds
  task automatic wr_reg(input logic [3:0] ad, input logic [15:0] d);
    @(posedge i_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    if (ad == `CCR_CORE_CTRL_OFF) begin
      v = d[15];
      m = d[13:12];
      a = d[7];
      b = d[6];
      s = d[5];
      sup = d[4];
      low = d[2:0];
      priority_level_msb = priority_level_msb & d[3];
      if (d[11] && dp > 0) begin
        dp--;
        exp_terms++;
      end
    end
  endtask
  task automatic rd_reg(input logic [3:0] ad);
    @(posedge i_clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk("rdata", ad == 4'h0 ? exp_rd() : 16'h0000, rdata);
    chk("ctrl", {5'h00, v[0], m[1:0], a[0], b[0], s[0], sup[0],
      priority_level_msb[0], low_bits}, {5'h00, ctrl});
    chk("depth", 16'(dp[2:0]), 16'(depth));
    chk("terms", 16'(exp_terms), 16'(terms));
  endtask
  task automatic conclude();
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well past the length of the sequence below
  always @(posedge i_clk) begin
    cyc++;
    if (term === 1'b1) terms++;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    logic [15:0] d;
    low = $urandom(65944);
    {v, m, a, b, sup, priority_level_msb, low, dp} = '0;
    s = 1;
    low_bits <= 3'($urandom);
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_reg(4'h0);
    for (int i = 0; i < 12; i++) begin
      @(posedge i_clk);
      msb <= i[0];
      if (i == 6) low_bits <= 3'($urandom);
      @(posedge i_clk);
      msb <= 1'b0;
      priority_level_msb = priority_level_msb | i[0];
      d = 16'($urandom);
      d[13:12] = 2'(i % 3);
      wr_reg(4'h0, d);
      rd_reg(4'h0);
    end
    wr_reg(4'h5, 16'hffff);
    rd_reg(4'h5);
    repeat (8) begin
      @(posedge i_clk);
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      if (dp < 7) dp++;
    end
    repeat (3) @(posedge i_clk);
    rd_reg(4'h0);
    repeat (2) begin
      wr_reg(4'h0, exp_rd() | 16'h0800);
      repeat (10) @(posedge i_clk);
      rd_reg(4'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
